// [adc_scan_pkg.sv]
// Constants and carrier types for the scan-mode decoder
package adc_scan_pkg;

  localparam int WORD_W    = 16;
  localparam int SELECT_BIT = 15;
  localparam int SCAN_MSB  = 14;
  localparam int SCAN_LSB  = 11;
  localparam int CHSEL_MSB = 10;
  localparam int CHSEL_LSB = 7;
  localparam int AUX_MSB   = 6;
  localparam int AUX_LSB   = 0;

  // Bits [6:3] and [1] that a no-change scan code may still update
  localparam logic [6:0] NULL_AUX_MASK = 7'h7A;

  localparam logic [3:0] SCAN_NULL       = 4'h0;
  localparam logic [3:0] SCAN_MANUAL     = 4'h1;
  localparam logic [3:0] SCAN_REPEAT     = 4'h2;
  localparam logic [3:0] SCAN_STD_INT    = 4'h3;
  localparam logic [3:0] SCAN_STD_EXT    = 4'h4;
  localparam logic [3:0] SCAN_UPPER_INT  = 4'h5;
  localparam logic [3:0] SCAN_UPPER_EXT  = 4'h6;
  localparam logic [3:0] SCAN_CUSTOM_INT = 4'h7;
  localparam logic [3:0] SCAN_CUSTOM_EXT = 4'h8;
  localparam logic [3:0] SCAN_SEQUENCE   = 4'h9;

  localparam logic [3:0] SCAN_RST  = 4'h1;
  localparam logic [3:0] CHSEL_RST = 4'h0;
  localparam logic [6:0] AUX_RST   = 7'h00;

  localparam logic [3:0] TOP_CH_16 = 4'hF;
  localparam logic [3:0] TOP_CH_8  = 4'h7;
  localparam logic [4:0] CUSTOM_MAX_CONV = 5'h10;
  localparam logic [8:0] SEQUENCE_MAX_CONV = 9'h100;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RANGE  = 4'h2;
  localparam logic [3:0] REG_LINK   = 4'h3;

  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] chsel;
    logic [6:0] aux;
  } scan_cfg_t;

  typedef struct packed {
    logic accepted;
    logic internal_clk;
    logic avg_allowed;
    logic custom_list;
    logic sequence_list;
  } mode_attr_t;

  typedef struct packed {
    logic [3:0] first_ch;
    logic [3:0] last_ch;
    logic [4:0] count;
  } scan_range_t;

endpackage

// [serial_word_rx.sv]
// Link-clock receiver: shifts in 16-bit words framed by chip select
`timescale 1ns/1ps
module serial_word_rx (
  input  wire logic        sclk,      // Serial clock from host
  input  wire logic        rstn,      // Async reset, active low
  input  wire logic        cs_n,      // Chip select, active low
  input  wire logic        din,       // Serial data, MSB first
  output logic [15:0]      word_q,    // Last complete word
  output logic             toggle_q   // Flips once per complete word
);

  logic        frame_rstn;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  bit_cnt_d;
  logic [14:0] shift_q;
  logic [14:0] shift_d;
  logic [15:0] word_d;
  logic        toggle_d;

  // Counter restarts whenever chip select is high, so idle sclk is harmless
  assign frame_rstn = rstn & ~cs_n;

  always_comb
  begin
    bit_cnt_d = bit_cnt_q + 4'h1;
    shift_d   = {shift_q[13:0], din};
    word_d    = word_q;
    toggle_d  = toggle_q;
    if (bit_cnt_q == 4'hF)
    begin
      word_d   = {shift_q, din};
      toggle_d = ~toggle_q;
    end
  end

  always_ff @(posedge sclk or negedge frame_rstn)
  begin
    if (!frame_rstn)
    begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 15'h0000;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
    end
  end

  // Held until the next full word, long enough for the other domain
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_q   <= 16'h0000;
      toggle_q <= 1'b0;
    end
    else
    begin
      word_q   <= word_d;
      toggle_q <= toggle_d;
    end
  end

endmodule

// [adc_scan_mode_decoder.sv]
// Scan-mode and channel-select decoder with serial and register paths
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Standard external: channels zero..N, serial clock
// - Upper internal: N..top, 16-N or 8-N results
// - Upper: internal averages, external serial-clock no averaging
// - Custom: ascending unique list, at most 16
// - Custom internal averages; custom external does not
// - Sequence: up to 256 entries, serial clock
// - Codes 1010-1111 keep mode, ignore bits 10:0
// - Channel field sets boundary channel N
// - Channel field decoded as plain binary
// - Code 0000 keeps mode and channel, updates bits 6:3 and 1 only
module adc_scan_mode_decoder (
  input  wire logic                     clk,           // System clock
  input  wire logic                     rstn,          // Async reset, low
  input  wire logic [3:0]               addr,          // Register index
  input  wire logic [31:0]              wdata,         // Write data
  input  wire logic                     wr,            // Write strobe
  input  wire logic                     rd,            // Read strobe
  output logic [31:0]                   rdata,         // Read data
  input  wire logic                     sclk,          // Serial clock
  input  wire logic                     cs_n,          // Chip select, low
  input  wire logic                     din,           // Serial data in
  input  wire logic                     sixteen_ch,    // Part has 16 inputs
  output adc_scan_pkg::scan_cfg_t       cfg,           // Held settings
  output logic                          internal_clk,  // Internal clock mode
  output logic                          avg_allowed,   // Averaging allowed
  output logic                          custom_list,   // Use custom list
  output logic                          sequence_list, // Use stored sequence
  output adc_scan_pkg::scan_range_t     range          // Scan range
);

  // Attributes of one scan code
  function automatic adc_scan_pkg::mode_attr_t mode_attr(
    input logic [3:0] scan
  );
    adc_scan_pkg::mode_attr_t a;
    a = '0;
    unique case (scan)
      adc_scan_pkg::SCAN_MANUAL:
        a.accepted = 1'b1;
      adc_scan_pkg::SCAN_REPEAT,
      adc_scan_pkg::SCAN_STD_INT:
      begin
        a.accepted     = 1'b1;
        a.internal_clk = 1'b1;
        a.avg_allowed  = 1'b1;
      end
      adc_scan_pkg::SCAN_STD_EXT:
        a.accepted = 1'b1;
      adc_scan_pkg::SCAN_UPPER_INT:
      begin
        a.accepted     = 1'b1;
        a.internal_clk = 1'b1;
        a.avg_allowed  = 1'b1;
      end
      adc_scan_pkg::SCAN_UPPER_EXT:
        a.accepted = 1'b1;
      adc_scan_pkg::SCAN_CUSTOM_INT:
      begin
        a.accepted     = 1'b1;
        a.internal_clk = 1'b1;
        a.avg_allowed  = 1'b1;
        a.custom_list  = 1'b1;
      end
      adc_scan_pkg::SCAN_CUSTOM_EXT:
      begin
        a.accepted    = 1'b1;
        a.custom_list = 1'b1;
      end
      adc_scan_pkg::SCAN_SEQUENCE:
      begin
        a.accepted      = 1'b1;
        a.sequence_list = 1'b1;
      end
      default:
        a.accepted = 1'b0;
    endcase
    return a;
  endfunction

  // Apply one mode-control word to the held settings
  function automatic adc_scan_pkg::scan_cfg_t apply_word(
    input adc_scan_pkg::scan_cfg_t cur,
    input logic [15:0]             w
  );
    adc_scan_pkg::scan_cfg_t    n;
    adc_scan_pkg::mode_attr_t   at;
    logic [3:0]                 scan;
    logic [6:0]                 aux;
    n    = cur;
    scan = w[adc_scan_pkg::SCAN_MSB:adc_scan_pkg::SCAN_LSB];
    aux  = w[adc_scan_pkg::AUX_MSB:adc_scan_pkg::AUX_LSB];
    at   = mode_attr(scan);
    if (w[adc_scan_pkg::SELECT_BIT] == 1'b0)
    begin
      if (scan == adc_scan_pkg::SCAN_NULL)
      begin
        n.aux = (cur.aux & ~adc_scan_pkg::NULL_AUX_MASK)
              | (aux & adc_scan_pkg::NULL_AUX_MASK);
      end
      else if (at.accepted)
      begin
        n.scan  = scan;
        n.chsel = w[adc_scan_pkg::CHSEL_MSB:adc_scan_pkg::CHSEL_LSB];
        n.aux   = aux;
      end
    end
    return n;
  endfunction

  logic [15:0] link_word;
  logic        link_toggle;

  serial_word_rx u_rx (
    .sclk     (sclk),
    .rstn     (rstn),
    .cs_n     (cs_n),
    .din      (din),
    .word_q   (link_word),
    .toggle_q (link_toggle)
  );

  // Crossing: toggle and strap through two flops each
  logic [1:0]  tog_sync_q;
  logic [1:0]  tog_sync_d;
  logic        tog_seen_q;
  logic        tog_seen_d;
  logic [1:0]  strap_sync_q;
  logic [1:0]  strap_sync_d;
  logic        word_event;

  always_comb
  begin
    tog_sync_d   = {tog_sync_q[0], link_toggle};
    tog_seen_d   = tog_sync_q[1];
    strap_sync_d = {strap_sync_q[0], sixteen_ch};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tog_sync_q   <= 2'h0;
      tog_seen_q   <= 1'b0;
      strap_sync_q <= 2'h0;
    end
    else
    begin
      tog_sync_q   <= tog_sync_d;
      tog_seen_q   <= tog_seen_d;
      strap_sync_q <= strap_sync_d;
    end
  end

  assign word_event = tog_sync_q[1] ^ tog_seen_q;

  // Held configuration; link word is stable while its event is seen
  adc_scan_pkg::scan_cfg_t cfg_q;
  adc_scan_pkg::scan_cfg_t cfg_d;
  logic [15:0]             last_link_q;
  logic [15:0]             last_link_d;

  always_comb
  begin
    cfg_d       = cfg_q;
    last_link_d = last_link_q;
    if (word_event)
    begin
      cfg_d       = apply_word(cfg_q, link_word);
      last_link_d = link_word;
    end
    if (wr && addr == adc_scan_pkg::REG_CTRL)
      cfg_d = apply_word(cfg_d, wdata[15:0]);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q       <= '{adc_scan_pkg::SCAN_RST, adc_scan_pkg::CHSEL_RST,
                       adc_scan_pkg::AUX_RST};
      last_link_q <= 16'h0000;
    end
    else
    begin
      cfg_q       <= cfg_d;
      last_link_q <= last_link_d;
    end
  end

  // Decoded outputs, registered from the held configuration
  adc_scan_pkg::mode_attr_t  attr;
  adc_scan_pkg::scan_range_t range_d;
  adc_scan_pkg::scan_range_t range_q;
  adc_scan_pkg::mode_attr_t  attr_q;
  logic [3:0]                top_ch;
  logic [3:0]                n_ch;

  always_comb
  begin
    attr    = mode_attr(cfg_q.scan);
    top_ch  = strap_sync_q[1] ? adc_scan_pkg::TOP_CH_16
                              : adc_scan_pkg::TOP_CH_8;
    n_ch    = cfg_q.chsel;
    range_d = '0;
    unique case (cfg_q.scan)
      adc_scan_pkg::SCAN_STD_INT,
      adc_scan_pkg::SCAN_STD_EXT:
      begin
        range_d.first_ch = 4'h0;
        range_d.last_ch  = n_ch;
        range_d.count    = {1'b0, n_ch} + 5'h01;
      end
      adc_scan_pkg::SCAN_UPPER_INT,
      adc_scan_pkg::SCAN_UPPER_EXT:
      begin
        range_d.first_ch = n_ch;
        range_d.last_ch  = top_ch;
        if (n_ch <= top_ch)
          range_d.count = {1'b0, top_ch} + 5'h01 - {1'b0, n_ch};
        else
          range_d.count = 5'h00;
      end
      adc_scan_pkg::SCAN_CUSTOM_INT,
      adc_scan_pkg::SCAN_CUSTOM_EXT:
      begin
        range_d.first_ch = 4'h0;
        range_d.last_ch  = top_ch;
        range_d.count    = adc_scan_pkg::CUSTOM_MAX_CONV;
      end
      adc_scan_pkg::SCAN_MANUAL,
      adc_scan_pkg::SCAN_REPEAT:
      begin
        range_d.first_ch = n_ch;
        range_d.last_ch  = n_ch;
        range_d.count    = 5'h01;
      end
      default:
        range_d = '0; // Sequence length lives in the stored list
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      range_q <= '0;
      attr_q  <= '0;
    end
    else
    begin
      range_q <= range_d;
      attr_q  <= attr;
    end
  end

  // Register read port, data valid in the cycle after the strobe
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        adc_scan_pkg::REG_CTRL:
          rdata_d = {16'h0000, 1'b0, cfg_q.scan, cfg_q.chsel, cfg_q.aux};
        adc_scan_pkg::REG_STATUS:
          rdata_d = {26'h0000000, strap_sync_q[1], attr_q};
        adc_scan_pkg::REG_RANGE:
          rdata_d = {19'h00000, range_q};
        adc_scan_pkg::REG_LINK:
          rdata_d = {16'h0000, last_link_q};
        default:
          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign rdata         = rdata_q;
  assign cfg           = cfg_q;
  assign internal_clk  = attr_q.internal_clk;
  assign avg_allowed   = attr_q.avg_allowed;
  assign custom_list   = attr_q.custom_list;
  assign sequence_list = attr_q.sequence_list;
  assign range         = range_q;

endmodule

// [adc_scan_mode_decoder_checker.sv]
// Port assertions for the scan-mode decoder
`timescale 1ns/1ps
module decoder_checker (
  input wire logic                      clk,   // System clock
  input wire logic                      rstn,  // Reset, active low
  input wire logic [3:0]                addr,  // Register index
  input wire logic [31:0]               wdata, // Write data
  input wire logic                      wr,    // Write strobe
  input wire adc_scan_pkg::scan_cfg_t   cfg,   // Held settings
  input wire logic                      internal_clk,  // Internal clock
  input wire logic                      avg_allowed,   // Averaging
  input wire logic                      custom_list,   // Custom list
  input wire logic                      sequence_list, // Stored list
  input wire adc_scan_pkg::scan_range_t range  // Scan range
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic ctl_wr;
  assign ctl_wr = wr && addr == 4'h0;
  std_ext_a:
    assert property (cfg.scan == 4'h4 |=> !internal_clk && !avg_allowed
      && range.first_ch == 4'h0 && range.last_ch == $past(cfg.chsel))
    else $error("standard scan decode wrong");
  upper_int_a:
    assert property (cfg.scan == 4'h5 |=> internal_clk && avg_allowed
      && range.first_ch == $past(cfg.chsel))
    else $error("upper internal decode wrong");
  custom_int_a:
    assert property (cfg.scan == 4'h7 |=> internal_clk && avg_allowed
      && custom_list && range.count == 5'h10)
    else $error("custom internal decode wrong");
  custom_ext_a:
    assert property (cfg.scan == 4'h8 |=> !internal_clk && !avg_allowed
      && custom_list)
    else $error("custom external decode wrong");
  seq_mode_a:
    assert property (cfg.scan == 4'h9 |=> sequence_list && !internal_clk
      && !avg_allowed)
    else $error("sequence decode wrong");
  null_high_a:
    assert property (ctl_wr && (wdata[15] || wdata[14:11] >= 4'hA)
      |=> $stable(cfg))
    else $error("ignored word changed settings");
  null_zero_a:
    assert property (ctl_wr && wdata[15:11] == 5'h00 |=> cfg.scan ==
      $past(cfg.scan) && cfg.chsel == $past(cfg.chsel))
    else $error("no-change code altered mode");
  chsel_set_a:
    assert property (ctl_wr && wdata[15:11] inside {[5'h01:5'h09]}
      |=> cfg.chsel == $past(wdata[10:7]))
    else $error("channel field not taken");
  cover property (cfg.scan == 4'h9);
  cover property (ctl_wr && wdata[14:11] == 4'hF);
  cover property (cfg.scan == 4'h6 ##1 range.last_ch == 4'h7);
endmodule

bind adc_scan_mode_decoder decoder_checker decoder_checker_inst (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .cfg(cfg), .internal_clk(internal_clk), .avg_allowed(avg_allowed),
  .custom_list(custom_list), .sequence_list(sequence_list),
  .range(range));

// [serial_host_model.sv]
// Host side of the serial link, framing 16-bit words
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk, // Link clock, still between frames
  output logic cs_n, // Chip select, active low
  output logic din   // Serial data, MSB first
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end
  // 30 ns period; data changes while sclk is low
  task automatic send(input logic [15:0] w);
    #3.7 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      din = w[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    din = ~din; // Released line must not keep its last level
  endtask
endmodule

// [adc_scan_mode_decoder_bench.sv]
// Self-checking bench for the scan-mode decoder
`timescale 1ns/1ps
module adc_scan_mode_decoder_bench;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  logic [3:0]                addr = 4'h0;
  logic [31:0]               wdata = 32'h0;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic                      sixteen_ch = 1'b1;
  logic [31:0]               rdata;
  logic [31:0]               got;
  logic                      sclk;
  logic                      cs_n;
  logic                      din;
  logic                      internal_clk;
  logic                      avg_allowed;
  logic                      custom_list;
  logic                      sequence_list;
  adc_scan_pkg::scan_cfg_t   cfg;
  adc_scan_pkg::scan_range_t range;
  int                        errors = 0;
  int                        n_compared = 0;
  always #5 clk = ~clk;
  serial_host_model serial_host_model_inst (
    .sclk(sclk), .cs_n(cs_n), .din(din));
  adc_scan_mode_decoder adc_scan_mode_decoder_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sclk(sclk), .cs_n(cs_n), .din(din),
    .sixteen_ch(sixteen_ch), .cfg(cfg), .internal_clk(internal_clk),
    .avg_allowed(avg_allowed), .custom_list(custom_list),
    .sequence_list(sequence_list), .range(range));
  task automatic chk(input string what, input logic [31:0] exp, seen);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Mode word with the select bit cleared
  task automatic setm(input logic [3:0] s, c, input logic [6:0] x);
    wr_reg(4'h0, {17'h0, s, c, x});
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Attributes {internal, avg, custom, sequence}, range by both paths
  task automatic chk_out(input logic [3:0] a, input logic [12:0] r);
    chk("attr", {28'h0, a},
      {28'h0, internal_clk, avg_allowed, custom_list, sequence_list});
    chk("range", {19'h0, r}, {19'h0, range});
    rd_reg(4'h2, got);
    chk("range read", {19'h0, r}, got);
  endtask
  task automatic t_reset;
    chk("reset cfg", 32'h0800, {17'h0, cfg});
    chk_out(4'h0, {4'h0, 4'h0, 5'h01});
  endtask
  task automatic t_standard;
    logic [3:0] n;
    for (int i = 0; i < 16; i++)
    begin
      n = i[3:0];
      setm(4'h4, n, 7'h00);
      chk_out(4'h0, {4'h0, n, {1'b0, n} + 5'h01});
    end
  endtask
  task automatic t_upper;
    setm(4'h5, 4'h5, 7'h00);
    chk_out(4'hC, {4'h5, 4'hF, 5'h0B});
    rd_reg(4'h1, got);
    chk("status", 32'h0000003C, got);
    setm(4'h6, 4'h5, 7'h00);
    chk_out(4'h0, {4'h5, 4'hF, 5'h0B});
    @(posedge clk);
    sixteen_ch <= 1'b0;
    setm(4'h5, 4'h3, 7'h00);
    chk_out(4'hC, {4'h3, 4'h7, 5'h05});
    setm(4'h6, 4'hA, 7'h00);
    chk_out(4'h0, {4'hA, 4'h7, 5'h00});
    @(posedge clk);
    sixteen_ch <= 1'b1;
  endtask
  task automatic t_lists;
    setm(4'h7, 4'h2, 7'h00);
    chk_out(4'hE, {4'h0, 4'hF, 5'h10});
    setm(4'h8, 4'h2, 7'h00);
    chk_out(4'h2, {4'h0, 4'hF, 5'h10});
    setm(4'h9, 4'h2, 7'h00);
    chk_out(4'h1, 13'h0000);
    // Modes outside the documented table still decode as chosen
    setm(4'h3, 4'h9, 7'h00);
    chk_out(4'hC, {4'h0, 4'h9, 5'h0A});
    setm(4'h2, 4'h6, 7'h00);
    chk_out(4'hC, {4'h6, 4'h6, 5'h01});
    setm(4'h1, 4'h4, 7'h00);
    chk_out(4'h0, {4'h4, 4'h4, 5'h01});
  endtask
  task automatic t_null;
    setm(4'h4, 4'h7, 7'h00);
    for (int s = 10; s < 16; s++)
      wr_reg(4'h0, {17'h0, s[3:0], 4'hE, 7'h7F});
    wr_reg(4'h0, 32'h0000A3FF);
    repeat (3) @(posedge clk);
    #1 chk("cfg kept", 32'h2380, {17'h0, cfg});
    setm(4'h0, 4'hF, 7'h7F);
    chk("cfg aux", 32'h23FA, {17'h0, cfg});
    chk_out(4'h0, {4'h0, 4'h7, 5'h08});
    rd_reg(4'hC, got);
    chk("unmapped", 32'h0, got);
  endtask
  task automatic t_link;
    serial_host_model_inst.send(16'h3600);
    repeat (8) @(posedge clk);
    #1 chk_out(4'h0, {4'hC, 4'hF, 5'h04});
    rd_reg(4'h3, got);
    chk("link word", 32'h3600, got);
    serial_host_model_inst.send(16'hB000);
    repeat (8) @(posedge clk);
    #1 chk("link select", 32'h3600, {17'h0, cfg});
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 t_reset();
    t_standard();
    t_upper();
    t_lists();
    t_null();
    t_link();
    results();
  end
  initial
  begin
    #100000;
    errors++;
    results();
  end
endmodule
